//--- src/adc_seq.sv
// Sequencer, result memory and parallel interface of a four-channel
// simultaneous-sampling converter.
// Assumes the analog core delivers a finished result on i_conv_data when
// this block pulses o_conv_start and waits the conversion time.

// What this block does
// - A conversion sequence starts on the rising edge of sample start.
// - At that edge all four track/holds of the chosen bank go to hold.
// - Start edges are ignored until the last channel has converted.
// - Each channel converts in 3 us and lands in a 4x14 result memory.
// - One to four channels are converted from either of two banks.
// - All timing comes from the clock, the start strobe and the mode.
// - After the last conversion interrupt goes low and holds release.
// - Results are read in fixed order, channel one first.
// - After all programmed channels are read the pointer wraps to one.
// - Chip select may stay low across many reads, one result per read.
// - Results sit on bits 13..0; the low four bits carry the mode code.
// - Mode bit 3 is power-down, bit 2 bank, bits 1..0 count minus one.
// - The mode code latches on write strobe or chip select rising.
// - First read fall clears interrupt; each read rise moves pointer.
// - With chip select high read and write strobes are ignored and bus floats; start is not.
module adc_seq
  import adc_seq_pkg::*;
#(
  parameter int CONV_CYC = adc_seq_pkg::CONV_CYCLES
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_sample_start_n,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_rd_n,
  input  wire logic                         i_wr_n,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] i_result_bus,
  input  wire adc_seq_pkg::sample_t         i_conv_data,
  output logic [adc_seq_pkg::RESULT_W-1:0]  o_result_bus,
  output logic                              o_result_bus_oe,
  output logic                              o_int_n,
  output logic [adc_seq_pkg::NUM_CH-1:0]    o_hold,
  output logic                              o_bank_b,
  output logic                              o_power_down,
  output logic                              o_conv_start,
  output logic [1:0]                        o_conv_channel
);
  import adc_seq_pkg::*;

  // The slot timer is sixteen bits, so longer slots cannot be counted.
  if (CONV_CYC < 1 || CONV_CYC > 65535) begin : gen_conv_cyc_check
    $error("CONV_CYC out of range");
  end

  // Two-flop synchronisers; the first stage feeds only the second.
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] prev_reg;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= 4'hF;
      sync_reg <= 4'hF;
      prev_reg <= 4'hF;
    end else begin
      meta_reg <= {i_sample_start_n, i_cs_n, i_rd_n, i_wr_n};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic st_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic st_p;
  logic cs_p;
  logic rd_p;
  logic wr_p;
  assign {st_s, cs_s, rd_s, wr_s} = sync_reg;
  assign {st_p, cs_p, rd_p, wr_p} = prev_reg;

  // Read and write edges qualified by chip select, so a high select masks them; start is not.
  logic start_rise;
  logic rd_fall;
  logic rd_rise;
  logic wr_latch;
  assign start_rise = st_s & ~st_p;
  assign rd_fall    = ~cs_p & ~cs_s & rd_p & ~rd_s;
  assign rd_rise    = ~cs_p & ~rd_p & rd_s;
  // Latch on whichever of write or select rises first while both were low.
  assign wr_latch   = ~cs_p & ~wr_p & (wr_s | cs_s);

  // The code bits are held stable around the strobe by setup and hold.
  logic [MODE_W-1:0] mode_reg;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_reg <= MODE_RESET;
    end else if (wr_latch) begin
      mode_reg <= i_result_bus[MODE_W-1:0];
    end
  end

  // The code moves only on a qualified latch event, and then to the bus.
  AST_MODE_LATCH: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_latch
      |=> mode_reg == $past(i_result_bus[MODE_W-1:0]))
    else $error("mode not latched");
  AST_MODE_HOLD: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !wr_latch
      |=> $stable(mode_reg))
    else $error("mode moved without a latch");

  mode_t mode;
  assign mode = decode_mode(mode_reg);

  // Conversion sequencer.
  seq_state_t        state_reg;
  logic [15:0]       cyc_reg;
  logic [1:0]        ch_reg;
  logic [1:0]        last_reg;
  logic              done_pulse;
  assign done_pulse = (state_reg == ST_CONVERT) &&
                      (cyc_reg == 16'(CONV_CYC - 1)) && (ch_reg == last_reg);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg      <= ST_IDLE;
      cyc_reg        <= 16'h0000;
      ch_reg         <= 2'h0;
      last_reg       <= 2'h0;
      o_hold         <= 4'h0;
      o_bank_b       <= 1'b0;
      o_conv_start   <= 1'b0;
      o_conv_channel <= 2'h0;
    end else begin
      o_conv_start <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          // Power-down keeps the start edge from launching anything.
          if (start_rise && !mode.power_down) begin
            state_reg      <= ST_CONVERT;
            o_hold         <= 4'hF;
            o_bank_b       <= mode.bank_b;
            last_reg       <= mode.count_m1;
            ch_reg         <= 2'h0;
            cyc_reg        <= 16'h0000;
            o_conv_start   <= 1'b1;
            o_conv_channel <= 2'h0;
          end
        end
        ST_CONVERT: begin
          // Start edges are simply not looked at in this state.
          if (cyc_reg == 16'(CONV_CYC - 1)) begin
            cyc_reg <= 16'h0000;
            if (ch_reg == last_reg) begin
              state_reg <= ST_IDLE;
              o_hold    <= 4'h0;
            end else begin
              ch_reg         <= ch_reg + 2'h1;
              o_conv_start   <= 1'b1;
              o_conv_channel <= ch_reg + 2'h1;
            end
          end else begin
            cyc_reg <= cyc_reg + 16'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Sequencer checks: start, hold, slot timing and refused starts.
  AST_HOLD_ON_START: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_reg == ST_IDLE && start_rise && !mode.power_down)
      |=> o_hold == 4'hF)
    else $error("hold not set at start");
  AST_START_GO: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_reg == ST_IDLE && start_rise && !mode.power_down)
      |=> state_reg == ST_CONVERT)
    else $error("start missed");
  AST_IGNORE_START: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_reg == ST_CONVERT && start_rise && !done_pulse)
      |=> (state_reg == ST_CONVERT && $stable(last_reg) && $stable(o_bank_b)
           && (cyc_reg != 16'h0000 || $past(cyc_reg) == 16'(CONV_CYC - 1))))
    else $error("restart in sequence");
  AST_CONV_TIME: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_conv_start
      |-> (state_reg == ST_CONVERT && cyc_reg == 16'h0000))
    else $error("channel timer wrong");
  AST_SLOT_NEXT: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_reg == ST_CONVERT && cyc_reg == 16'(CONV_CYC - 1) && !done_pulse)
      |=> (o_conv_start && o_conv_channel == $past(ch_reg) + 2'h1))
    else $error("next channel not launched");
  AST_PD_BLOCK: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (state_reg == ST_IDLE && mode.power_down)
      |=> (state_reg == ST_IDLE && !o_conv_start))
    else $error("start taken in power-down");
  AST_HOLD_STAYS: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    state_reg == ST_CONVERT
      |-> o_hold == 4'hF)
    else $error("hold dropped mid sequence");

  // Result memory, written at the end of each channel's conversion time.
  logic [RESULT_W-1:0] mem [NUM_CH];
  always_ff @(posedge i_ref_clk) begin
    if (state_reg == ST_CONVERT && cyc_reg == 16'(CONV_CYC - 1)) begin
      mem[ch_reg] <= i_conv_data.value;
    end
  end

  // Programmed count captured at start, used to wrap the read pointer.
  logic [1:0] rd_ptr_reg;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_ptr_reg <= 2'h0;
    end else if (done_pulse) begin
      rd_ptr_reg <= 2'h0;
    end else if (rd_rise) begin
      if (rd_ptr_reg == last_reg) begin
        rd_ptr_reg <= 2'h0;
      end else begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
    end
  end

  // Pointer checks: first word, step, wrap, and no motion without a read.
  AST_PTR_FIRST: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    done_pulse
      |=> rd_ptr_reg == 2'h0)
    else $error("not channel one");
  AST_PTR_WRAP: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (rd_rise && !done_pulse && rd_ptr_reg == last_reg)
      |=> rd_ptr_reg == 2'h0)
    else $error("pointer no wrap");
  AST_PTR_STEP: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (rd_rise && !done_pulse && rd_ptr_reg != last_reg)
      |=> rd_ptr_reg == $past(rd_ptr_reg) + 2'h1)
    else $error("pointer did not step");
  AST_PTR_STILL: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (!rd_rise && !done_pulse)
      |=> $stable(rd_ptr_reg))
    else $error("pointer moved without a read");
  AST_CS_MASK: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (cs_p && cs_s)
      |-> !(rd_rise || rd_fall || wr_latch))
    else $error("strobe taken while deselected");

  // Interrupt: a completion in the same cycle as a read fall wins.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_int_n <= 1'b1;
    end else if (done_pulse) begin
      o_int_n <= 1'b0;
    end else if (rd_fall) begin
      o_int_n <= 1'b1;
    end
  end

  // Interrupt checks: low at completion, high again only on a read fall.
  AST_INT_DONE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    done_pulse
      |=> (!o_int_n && o_hold == 4'h0))
    else $error("no interrupt at end");
  AST_INT_CLEAR: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (rd_fall && !done_pulse)
      |=> o_int_n)
    else $error("int not cleared");
  AST_INT_STAYS: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (!o_int_n && !rd_fall)
      |=> !o_int_n)
    else $error("int released without a read");

  // Bus drive: only while select and read are both low.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_result_bus    <= '0;
      o_result_bus_oe <= 1'b0;
      o_power_down    <= 1'b0;
    end else begin
      o_result_bus_oe <= ~cs_s & ~rd_s;
      o_result_bus    <= mem[rd_ptr_reg];
      o_power_down    <= mode.power_down;
    end
  end

  // Bus checks: float while deselected, drive while selected and reading.
  AST_CS_FLOAT: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    cs_s
      |=> !o_result_bus_oe)
    else $error("bus driven deselected");
  AST_OE_READ: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (!cs_s && !rd_s)
      |=> o_result_bus_oe)
    else $error("bus not driven on read");
endmodule

//--- common/adc_seq_pkg.sv
// Constants and carriers for the simultaneous-sampling converter sequencer.
// Assumes a single 250 MHz clock domain; all strobes arrive asynchronously.
package adc_seq_pkg;
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          CONV_TIME_NS     = 3000;
  localparam int          CONV_CYCLES      = (CONV_TIME_NS * 1000)
                                             / CLK_PERIOD_PS;
  localparam int          RESULT_W         = 14;
  localparam int          NUM_CH           = 4;
  localparam int          MODE_W           = 4;
  localparam int          MODE_PD_BIT      = 3;
  localparam int          MODE_BANK_BIT    = 2;
  localparam int          MODE_CNT_LSB     = 0;
  localparam logic [3:0]  MODE_RESET       = 4'h0;

  // Mode settings decoded from the four mode code bits.
  typedef struct packed {
    logic       power_down;
    logic       bank_b;
    logic [1:0] count_m1;
  } mode_t;

  // Sampled-data word from the analog front end.
  typedef struct packed {
    logic [RESULT_W-1:0] value;
  } sample_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01
  } seq_state_t;

  // Unpack a mode code into its fields.
  function automatic mode_t decode_mode(input logic [MODE_W-1:0] code);
    mode_t m;
    m.power_down = code[MODE_PD_BIT];
    m.bank_b     = code[MODE_BANK_BIT];
    m.count_m1   = code[MODE_CNT_LSB +: 2];
    return m;
  endfunction
endpackage

//--- dv/core_model.sv
// Behavioural analog core: answers every conversion slot with a word
// that encodes its bank and channel. Assumes the sequencer holds
// bank and channel steady across each slot.
module core_model (
  input  wire logic       i_bank_b,
  input  wire logic [1:0] i_channel,
  output adc_seq_pkg::sample_t o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  // A distinct word per bank and channel lets a read prove its order.
  assign o_data.value = {i_bank_b, 9'h000, i_channel, 2'h1};
endmodule

//--- dv/testbench.sv
// Self-checking bench for the converter sequencer.
// Assumes the core model above and a short conversion slot parameter.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  logic                ref_clk  = 1'b0;
  logic                rst      = 1'b1;
  logic                ss_n     = 1'b1;
  logic                cs_n     = 1'b1;
  logic                rd_n     = 1'b1;
  logic                wr_n     = 1'b1;
  logic [RESULT_W-1:0] host_bus = 14'h0000;
  logic [RESULT_W-1:0] rbus;
  logic [NUM_CH-1:0]   hold;
  logic [1:0]          cch;
  logic                oe, int_n, bank_b, pd, cstart;
  sample_t             conv_data;
  int                  err_total = 0;
  int                  tests_run = 0;
  int                  starts    = 0;
  bit                  hung      = 1'b0;
  wire logic [RESULT_W-1:0] bus_w = oe ? rbus : host_bus;
  adc_seq #(.CONV_CYC(4)) DUT (
    .i_ref_clk(ref_clk), .i_reset(rst), .i_sample_start_n(ss_n),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_result_bus(bus_w),
    .i_conv_data(conv_data), .o_result_bus(rbus), .o_result_bus_oe(oe),
    .o_int_n(int_n), .o_hold(hold), .o_bank_b(bank_b),
    .o_power_down(pd), .o_conv_start(cstart), .o_conv_channel(cch));
  core_model core (.i_bank_b(bank_b), .i_channel(cch), .o_data(conv_data));
  // The clock toggles every half period of 4 ns.
  always #2 ref_clk = ~ref_clk;
  // Slot pulses are counted to see how many channels really converted.
  always @(posedge ref_clk) if (cstart === 1'b1) starts <= starts + 1;
  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Levels are held four cycles so the synchronisers see each one.
  task automatic write_mode(input logic [3:0] code, input bit sel, cs_1st);
    tick(1);
    cs_n <= !sel;
    host_bus <= 14'(code);
    tick(4);
    wr_n <= 1'b0;
    tick(4);
    if (cs_1st) cs_n <= 1'b1;
    else wr_n <= 1'b1;
    tick(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    host_bus <= ~14'(code);
    tick(4);
  endtask
  task automatic start_seq();
    tick(1);
    ss_n <= 1'b0;
    tick(4);
    ss_n <= 1'b1;
    tick(4);
  endtask
  task automatic read_word(input logic [15:0] exp);
    tick(1);
    rd_n <= 1'b0;
    tick(5);
    @(negedge ref_clk);
    chk("int_n", int_n, 1);
    chk("oe", oe, 1);
    chk("data", rbus, exp);
    tick(1);
    rd_n <= 1'b1;
    tick(5);
    @(negedge ref_clk);
    chk("oe_off", oe, 0);
  endtask
  // One whole sequence: start, wait for completion, read n plus one words.
  task automatic run_seq(input logic [3:0] code, input bit again);
    int n;
    int k;
    int base;
    n = code[1:0] + 1;
    base = starts;
    start_seq();
    @(negedge ref_clk);
    chk("hold", hold, 4'hF);
    chk("bank", bank_b, code[2]);
    if (again) start_seq();
    k = 0;
    while (int_n !== 1'b0 && k < 200) begin
      tick(1);
      k++;
    end
    if (int_n !== 1'b0) begin
      err_total++;
      hung = 1'b1;
      return;
    end
    @(negedge ref_clk);
    chk("release", hold, 0);
    chk("slots", 16'(starts - base), 16'(n));
    tick(1);
    cs_n <= 1'b0;
    for (int i = 0; i <= n; i++)
      read_word({2'h0, code[2], 9'h000, 2'(i % n), 2'h1});
    tick(1);
    cs_n <= 1'b1;
    // Select stays high long enough for the synchronisers to see it.
    tick(4);
  endtask
  // Main sequence: defaults, every mode, refusals, then power-down.
  initial begin
    tick(6);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("int_rst", int_n, 1);
    chk("pd_rst", pd, 0);
    run_seq(4'h0, 1'b0);
    for (int c = 1; c < 8 && !hung; c++) begin
      write_mode(4'(c), 1'b1, c[0]);
      run_seq(4'(c), c == 3);
    end
    // A hung sequence skips straight to the verdict.
    if (!hung) begin
      rd_n <= 1'b0;
      tick(5);
      @(negedge ref_clk);
      chk("oe_cs_high", oe, 0);
      tick(1);
      rd_n <= 1'b1;
      write_mode(4'h8, 1'b0, 1'b0);
      @(negedge ref_clk);
      chk("pd_cs_high", pd, 0);
      write_mode(4'h8, 1'b1, 1'b1);
      @(negedge ref_clk);
      chk("pd", pd, 1);
      start_seq();
      tick(8);
      @(negedge ref_clk);
      chk("pd_hold", hold, 0);
    end
    end_of_test();
  end
endmodule
